// [design/frs_section_ctrl.sv]
// Section access control for self-programming of program flash
//
// Design decisions made here: the plain strobed port and the address map.
module frs_section_ctrl (
    input  wire logic        SYS_CLK_I,
    input  wire logic        NRST_I,
    // Processor side
    input  wire logic        STORE_I,
    input  wire logic [1:0]  STORE_OP_I,
    input  wire logic [15:0] EXEC_ADDR_I,
    input  wire logic [15:0] POINTER_I,
    input  wire logic [3:0]  STORE_DATA_I,
    output logic             CPU_HALT_O,
    output logic             STORE_IGNORED_O,
    output logic             STORE_REFUSED_O,
    output logic             CONC_BUSY_O,
    // Fuses, lock storage and programming interface
    input  wire logic [1:0]  BOOT_SIZE_FUSES_I,
    input  wire logic [3:0]  LOCK_STORED_I,
    input  wire logic        LOCK_PROG_I,
    input  wire logic [3:0]  LOCK_PROG_MASK_I,
    input  wire logic        CHIP_ERASE_I,
    output logic [3:0]       LOCK_BITS_O,
    // Flash array
    output logic             FLASH_GO_O,
    output logic             FLASH_ERASE_O,
    output logic [15:0]      FLASH_ADDR_O,
    input  wire logic        FLASH_DONE_I,
    // Register port
    input  wire logic [1:0]  REG_ADDR_I,
    input  wire logic [7:0]  REG_WDATA_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    output logic [7:0]       REG_RDATA_O
);

    // ==========================================================
    // Declarations
    frs_pkg::frs_state_type state_q;
    logic        loaded_q;
    logic [1:0]  boot_sz_q;
    logic [15:0] addr_q;
    logic        erase_q;
    logic        conc_q;
    logic        busy_q;
    logic        halt_q;
    logic        go_q;
    logic        ignored_q;
    logic        refused_q;
    logic        refused_sticky_q;
    logic [7:0]  rdata_q;
    logic [3:0]  lock_bits;

    logic        exec_in_boot;
    logic [15:0] exec_boot_start;
    logic        tgt_in_boot;
    logic        tgt_in_conc;
    logic [15:0] tgt_boot_start;

    logic        take;
    logic        is_page_op;
    logic        allowed;
    logic        start;
    logic        lock_sw_set;
    logic        ctrl_wr;
    logic        busy_clr;
    logic        refused_clr;

    // ==========================================================
    // Region classification
    frs_classify u_cls_exec (
        .addr_i            (EXEC_ADDR_I),
        .boot_size_fuses_i (boot_sz_q),
        .in_boot_o         (exec_in_boot),
        .in_conc_o         (),
        .boot_start_o      (exec_boot_start)
    );

    frs_classify u_cls_tgt (
        .addr_i            (POINTER_I),
        .boot_size_fuses_i (boot_sz_q),
        .in_boot_o         (tgt_in_boot),
        .in_conc_o         (tgt_in_conc),
        .boot_start_o      (tgt_boot_start)
    );

    // ==========================================================
    // Lock bits
    frs_lock_store u_lock (
        .clk_i      (SYS_CLK_I),
        .nrst_i     (NRST_I),
        .load_i     (!loaded_q),
        .load_val_i (LOCK_STORED_I),
        .set_i      (lock_sw_set || LOCK_PROG_I),
        .set_mask_i ((lock_sw_set ? STORE_DATA_I : 4'h0) |
                     (LOCK_PROG_I ? LOCK_PROG_MASK_I : 4'h0)),
        .erase_i    (CHIP_ERASE_I),
        .lock_o     (lock_bits)
    );

    // ==========================================================
    // Request decode
    assign take        = STORE_I && loaded_q && (state_q == frs_pkg::ST_IDLE);
    assign is_page_op  = (STORE_OP_I == frs_pkg::OP_PAGE_ERASE) ||
                         (STORE_OP_I == frs_pkg::OP_PAGE_WRITE);
    // Write-lock bit low means programmed, so writes are barred
    assign allowed     = tgt_in_boot ? lock_bits[frs_pkg::LOCK_BOOT_WR_BIT]
                                     : lock_bits[frs_pkg::LOCK_APP_WR_BIT];
    assign start       = take && exec_in_boot && is_page_op && allowed;
    assign lock_sw_set = take && exec_in_boot && (STORE_OP_I == frs_pkg::OP_LOCK_SET);
    assign ctrl_wr     = REG_WR_I && (REG_ADDR_I == frs_pkg::REG_CTRL);
    assign busy_clr    = ctrl_wr && REG_WDATA_I[frs_pkg::CTRL_BUSY_BIT];
    assign refused_clr = ctrl_wr && REG_WDATA_I[frs_pkg::CTRL_REFUSED_BIT];

    // ==========================================================
    // Fuse capture after reset release
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            loaded_q  <= 1'b0;
            boot_sz_q <= frs_pkg::FUSE_RESET;
        end else if (!loaded_q) begin
            loaded_q  <= 1'b1;
            boot_sz_q <= BOOT_SIZE_FUSES_I;
        end
    end

    // ==========================================================
    // Operation sequencing
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_q <= frs_pkg::ST_IDLE;
        end else begin
            case (state_q)
                frs_pkg::ST_IDLE: begin
                    if (start) begin
                        state_q <= frs_pkg::ST_RUN;
                    end
                end
                frs_pkg::ST_RUN: begin
                    if (FLASH_DONE_I) begin
                        state_q <= frs_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= frs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Latched target so the pointer is free once running
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            addr_q  <= frs_pkg::ADDR_RESET;
            erase_q <= 1'b0;
            conc_q  <= 1'b0;
        end else if (start) begin
            addr_q  <= POINTER_I;
            erase_q <= (STORE_OP_I == frs_pkg::OP_PAGE_ERASE);
            conc_q  <= tgt_in_conc;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            go_q      <= 1'b0;
            ignored_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            go_q      <= start;
            ignored_q <= take && (!exec_in_boot || (!is_page_op &&
                         (STORE_OP_I != frs_pkg::OP_LOCK_SET)));
            refused_q <= take && exec_in_boot && is_page_op && !allowed;
        end
    end

    // Halt only for a halting-region page, held until the array finishes
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            halt_q <= 1'b0;
        end else if (start) begin
            halt_q <= !tgt_in_conc;
        end else if (FLASH_DONE_I) begin
            halt_q <= 1'b0;
        end
    end

    // Busy survives completion; a new concurrent-region start beats a clear in the same cycle
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            busy_q <= 1'b0;
        end else if (start && tgt_in_conc) begin
            busy_q <= 1'b1;
        end else if (busy_clr && (state_q == frs_pkg::ST_IDLE)) begin
            busy_q <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            refused_sticky_q <= 1'b0;
        end else if (take && exec_in_boot && is_page_op && !allowed) begin
            refused_sticky_q <= 1'b1;
        end else if (refused_clr) begin
            refused_sticky_q <= 1'b0;
        end
    end

    // ==========================================================
    // Register read
    always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rdata_q <= frs_pkg::RDATA_RESET;
        end else if (REG_RD_I) begin
            case (REG_ADDR_I)
                frs_pkg::REG_CTRL: rdata_q <= {4'h0, refused_sticky_q,
                                               (state_q == frs_pkg::ST_RUN),
                                               halt_q, busy_q};
                frs_pkg::REG_LOCK: rdata_q <= {4'h0, lock_bits};
                frs_pkg::REG_FUSE: rdata_q <= {6'h00, boot_sz_q};
                default:           rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= frs_pkg::RDATA_RESET;
        end
    end

    // ==========================================================
    // Outputs
    assign CPU_HALT_O      = halt_q;
    assign STORE_IGNORED_O = ignored_q;
    assign STORE_REFUSED_O = refused_q;
    assign CONC_BUSY_O     = busy_q;
    assign LOCK_BITS_O     = lock_bits;
    assign FLASH_GO_O      = go_q;
    assign FLASH_ERASE_O   = erase_q;
    assign FLASH_ADDR_O    = addr_q;
    assign REG_RDATA_O     = rdata_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!NRST_I);

    AST_APP_IGNORED: assert property (
        take && !exec_in_boot |=> !go_q && ignored_q && (state_q == frs_pkg::ST_IDLE))
        else $error("store from application region was not ignored");

    AST_BOOT_WRITES_ANY: assert property (
        take && exec_in_boot && is_page_op && allowed |=> go_q && (addr_q == $past(POINTER_I)))
        else $error("permitted store from boot region did not start");

    AST_FUSE_SPLIT: assert property (
        loaded_q |-> (tgt_in_boot == (POINTER_I >=
                         ((boot_sz_q == 2'h0) ? frs_pkg::BOOT_START_SZ0 :
                          (boot_sz_q == 2'h1) ? frs_pkg::BOOT_START_SZ1 :
                          (boot_sz_q == 2'h2) ? frs_pkg::BOOT_START_SZ2 :
                                                frs_pkg::BOOT_START_SZ3))) &&
                     (tgt_boot_start == exec_boot_start))
        else $error("boot split does not follow fuses");

    AST_APP_LOCKED: assert property (
        take && exec_in_boot && is_page_op && !tgt_in_boot &&
        !lock_bits[frs_pkg::LOCK_APP_WR_BIT] |=> refused_q && !go_q)
        else $error("application lock did not refuse a write");

    AST_BOOT_LOCKED: assert property (
        take && exec_in_boot && is_page_op && tgt_in_boot &&
        !lock_bits[frs_pkg::LOCK_BOOT_WR_BIT] |=> refused_q && !go_q)
        else $error("boot lock did not refuse a write");

    AST_FIXED_LIMIT: assert property (
        go_q |-> conc_q == (FLASH_ADDR_O <= frs_pkg::CONC_END_ADDR))
        else $error("concurrent limit moved");

    AST_CONC_RUNS: assert property (
        go_q && conc_q |-> !CPU_HALT_O && CONC_BUSY_O)
        else $error("CPU halted for a concurrent-region page");

    AST_HALT_WHOLE: assert property (
        (state_q == frs_pkg::ST_RUN) && !conc_q |-> CPU_HALT_O)
        else $error("CPU not halted during halting-region programming");

    AST_HALT_ENDS_ON_DONE: assert property (
        $fell(halt_q) |-> $past(FLASH_DONE_I))
        else $error("halt released before completion");

    AST_BOOT_IN_HALT: assert property (
        tgt_boot_start > frs_pkg::CONC_END_ADDR)
        else $error("boot region overlaps concurrent region");

    AST_BUSY_READ: assert property (
        REG_RD_I && (REG_ADDR_I == frs_pkg::REG_CTRL) |=>
        REG_RDATA_O[frs_pkg::CTRL_BUSY_BIT] == $past(busy_q))
        else $error("busy flag misread");

    AST_BUSY_HOLDS: assert property (
        busy_q && !busy_clr ##1 FLASH_DONE_I |-> ##1 busy_q)
        else $error("busy flag dropped without software clear");

    AST_ADDR_LATCHED: assert property (
        (state_q == frs_pkg::ST_RUN) && $past(state_q == frs_pkg::ST_RUN) |-> $stable(addr_q))
        else $error("latched address changed while running");

endmodule : frs_section_ctrl

// [design/frs_pkg.sv]
// Constants, encodings and region limits for the flash section controller
// Notes on behaviour
// - Store-program run from the application region is ignored, nothing starts.
// - Store-program run from the boot region may erase or write any page.
// - Boot-size fuses set where the boot region starts.
// - First lock pair guards the application region.
// - Second lock pair guards the boot region, independently.
// - Concurrent-read limit is fixed, independent of any fuse.
// - Programming a concurrent-region page leaves the CPU running.
// - Programming a halting-region page halts the CPU for the whole operation.
// - Halt choice follows the programmed page, not the CPU's read address.
// - Boot region lies wholly inside the halting region for every size.
// - Busy flag reads one while concurrent-region reads are blocked.
// - Busy flag holds after completion until software clears it.
// - Target address is latched from the pointer when an operation starts.
// - Lock bits are set by software or programmer, cleared only by chip erase.
package frs_pkg;

    // ==========================================================
    // Geometry
    localparam int          ADDR_W        = 16;
    localparam int          DATA_W        = 8;
    localparam logic [15:0] CONC_END_ADDR = 16'hBFFF;

    // Boot region start per boot-size fuse code
    localparam logic [15:0] BOOT_START_SZ0 = 16'hC000;
    localparam logic [15:0] BOOT_START_SZ1 = 16'hE000;
    localparam logic [15:0] BOOT_START_SZ2 = 16'hF000;
    localparam logic [15:0] BOOT_START_SZ3 = 16'hF800;

    // ==========================================================
    // Store-program operation codes
    localparam logic [1:0] OP_PAGE_ERASE = 2'h0;
    localparam logic [1:0] OP_PAGE_WRITE = 2'h1;
    localparam logic [1:0] OP_LOCK_SET   = 2'h2;

    // ==========================================================
    // Register map
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_LOCK = 2'h1;
    localparam logic [1:0] REG_FUSE = 2'h2;

    localparam int CTRL_BUSY_BIT    = 0;
    localparam int CTRL_HALT_BIT    = 1;
    localparam int CTRL_ACTIVE_BIT  = 2;
    localparam int CTRL_REFUSED_BIT = 3;

    // Lock bits: [0] app write, [1] app read, [2] boot write, [3] boot read
    localparam int LOCK_APP_WR_BIT  = 0;
    localparam int LOCK_BOOT_WR_BIT = 2;

    // ==========================================================
    // Reset values
    localparam logic [3:0]  LOCK_RESET  = 4'h0;
    localparam logic [3:0]  LOCK_ERASED = 4'hF;
    localparam logic [1:0]  FUSE_RESET  = 2'h0;
    localparam logic [15:0] ADDR_RESET  = 16'h0000;
    localparam logic [7:0]  RDATA_RESET = 8'h00;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } frs_state_type;

endpackage : frs_pkg

// [design/frs_classify.sv]
// Region classifier for one flash byte address
module frs_classify (
    input  wire logic [15:0] addr_i,
    input  wire logic [1:0]  boot_size_fuses_i,
    output logic             in_boot_o,
    output logic             in_conc_o,
    output logic [15:0]      boot_start_o
);

    always_comb begin
        case (boot_size_fuses_i)
            2'h0:    boot_start_o = frs_pkg::BOOT_START_SZ0;
            2'h1:    boot_start_o = frs_pkg::BOOT_START_SZ1;
            2'h2:    boot_start_o = frs_pkg::BOOT_START_SZ2;
            default: boot_start_o = frs_pkg::BOOT_START_SZ3;
        endcase
    end

    assign in_boot_o = (addr_i >= boot_start_o);
    assign in_conc_o = (addr_i <= frs_pkg::CONC_END_ADDR);

endmodule : frs_classify

// [design/frs_lock_store.sv]
// Boot and general lock bits, programmed one way only
module frs_lock_store (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       load_i,
    input  wire logic [3:0] load_val_i,
    input  wire logic       set_i,
    input  wire logic [3:0] set_mask_i,
    input  wire logic       erase_i,
    output logic [3:0]      lock_o
);

    // Reset shows fully protected until the stored value is loaded
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_bit
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    lock_o[b] <= frs_pkg::LOCK_RESET[b];
                end else if (load_i) begin
                    lock_o[b] <= load_val_i[b];
                end else if (set_i && set_mask_i[b]) begin
                    lock_o[b] <= 1'b0;
                end else if (erase_i) begin
                    lock_o[b] <= frs_pkg::LOCK_ERASED[b];
                end
            end
        end
    endgenerate

endmodule : frs_lock_store

// [dv/frs_flash_model.sv]
// Flash array stand-in: answers each start pulse with a done pulse after a set delay
module frs_flash_model (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       go_i,
    input  wire logic [7:0] delay_i,
    output logic            done_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0] cnt_q;
    logic       done_q;

    // ==========================================================
    // Delay counter; delay_i of 1 answers promptly, larger values slowly
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q  <= 8'h00;
            done_q <= 1'b0;
        end else begin
            done_q <= (cnt_q == 8'h01);
            if (go_i) begin
                cnt_q <= delay_i;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end

    assign done_o = done_q;
endmodule : frs_flash_model

// [dv/frs_section_ctrl_tb.sv]
// Self-checking bench for the flash section controller
module frs_section_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk, nrst, store, lock_prog, chip_erase, go, erase, halt, ign, ref_, busy, done;
    logic reg_wr, reg_rd;
    logic [1:0]  store_op, fuses, reg_addr;
    logic [15:0] exec_addr, ptr, flash_addr;
    logic [3:0]  store_data, lock_stored, prog_mask, lock_bits;
    logic [7:0]  wdata, rdata, delay;
    int          fails, total_checks;

    frs_section_ctrl uut (.SYS_CLK_I(clk), .NRST_I(nrst), .STORE_I(store), .STORE_OP_I(store_op),
        .EXEC_ADDR_I(exec_addr), .POINTER_I(ptr), .STORE_DATA_I(store_data),
        .CPU_HALT_O(halt), .STORE_IGNORED_O(ign), .STORE_REFUSED_O(ref_), .CONC_BUSY_O(busy),
        .BOOT_SIZE_FUSES_I(fuses), .LOCK_STORED_I(lock_stored), .LOCK_PROG_I(lock_prog),
        .LOCK_PROG_MASK_I(prog_mask), .CHIP_ERASE_I(chip_erase), .LOCK_BITS_O(lock_bits),
        .FLASH_GO_O(go), .FLASH_ERASE_O(erase), .FLASH_ADDR_O(flash_addr),
        .FLASH_DONE_I(done), .REG_ADDR_I(reg_addr), .REG_WDATA_I(wdata), .REG_WR_I(reg_wr),
        .REG_RD_I(reg_rd), .REG_RDATA_O(rdata));

    frs_flash_model u_flash (.clk_i(clk), .nrst_i(nrst), .go_i(go), .delay_i(delay),
        .done_o(done));

    // ==========================================================
    // Clock, shared tasks
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish();
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic do_reset(input logic [1:0] f);
        fuses <= f;
        nrst  <= 1'b0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : do_reset

    task automatic reg_read(input logic [1:0] a, input logic [7:0] exp, input string name);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(name, {8'h00, exp}, {8'h00, rdata});
    endtask : reg_read

    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr   <= 1'b1;
        reg_addr <= a;
        wdata    <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask : reg_write

    // Leaves the answer cycle open for the caller to judge
    task automatic do_store(input logic [1:0] op, input logic [15:0] ex, input logic [15:0] p,
                            input logic [3:0] d);
        @(posedge clk);
        store      <= 1'b1;
        store_op   <= op;
        exec_addr  <= ex;
        ptr        <= p;
        store_data <= d;
        @(posedge clk);
        store <= 1'b0;
        ptr   <= ~p;
        #1;
    endtask : do_store

    // Halt must hold its level for the whole operation, then drop
    task automatic wait_done(input logic exp_halt);
        int n;
        for (n = 0; n < 300; n++) begin
            @(posedge clk);
            #1;
            chk("halt_during_op", {15'h0, exp_halt}, {15'h0, halt});
            if (done === 1'b1) break;
        end
        chk("done_seen", 16'h1, {15'h0, done});
        @(posedge clk);
        #1;
        chk("halt_after_op", 16'h0, {15'h0, halt});
    endtask : wait_done

    // ==========================================================
    // Scenarios
    task automatic t_fuse_split();
        logic [15:0] bs [4];
        int f;
        bs = '{frs_pkg::BOOT_START_SZ0, frs_pkg::BOOT_START_SZ1,
               frs_pkg::BOOT_START_SZ2, frs_pkg::BOOT_START_SZ3};
        for (f = 0; f < 4; f++) begin
            do_reset(f[1:0]);
            reg_read(frs_pkg::REG_FUSE, {6'h0, f[1:0]}, "fuse_reg");
            reg_read(frs_pkg::REG_LOCK, 8'h0F, "lock_reg");
            do_store(frs_pkg::OP_LOCK_SET, bs[f] - 16'h0002, 16'h0000, 4'h0);
            chk("ignored_app", 16'h1, {15'h0, ign});
            chk("go_app", 16'h0, {15'h0, go});
            do_store(frs_pkg::OP_LOCK_SET, bs[f], 16'h0000, 4'h0);
            chk("ignored_boot", 16'h0, {15'h0, ign});
        end
    endtask : t_fuse_split

    task automatic t_conc_write();
        delay = 8'd20;
        do_store(frs_pkg::OP_PAGE_WRITE, 16'hF800, 16'hBF80, 4'h0);
        chk("go", 16'h1, {15'h0, go});
        chk("addr", 16'hBF80, flash_addr);
        chk("erase_lvl", 16'h0, {15'h0, erase});
        chk("busy_set", 16'h1, {15'h0, busy});
        reg_read(frs_pkg::REG_CTRL, 8'h05, "ctrl_running");
        reg_write(frs_pkg::REG_CTRL, 8'h01);
        chk("busy_run_clr", 16'h1, {15'h0, busy});
        wait_done(1'b0);
        chk("busy_held", 16'h1, {15'h0, busy});
        reg_read(frs_pkg::REG_CTRL, 8'h01, "ctrl_after");
        reg_write(frs_pkg::REG_CTRL, 8'h01);
        chk("busy_clear", 16'h0, {15'h0, busy});
    endtask : t_conc_write

    task automatic t_halt_ops();
        delay = 8'd12;
        do_store(frs_pkg::OP_PAGE_ERASE, 16'hFC00, 16'hC000, 4'h0);
        chk("go_halting_region", 16'h1, {15'h0, go});
        chk("erase_lvl", 16'h1, {15'h0, erase});
        chk("halt_set", 16'h1, {15'h0, halt});
        chk("busy_halting_region", 16'h0, {15'h0, busy});
        wait_done(1'b1);
        delay = 8'd1;
        do_store(frs_pkg::OP_PAGE_WRITE, 16'hFC00, 16'hF900, 4'h0);
        chk("go_boot", 16'h1, {15'h0, go});
        chk("addr_boot", 16'hF900, flash_addr);
        wait_done(1'b1);
    endtask : t_halt_ops

    task automatic t_locks();
        do_store(frs_pkg::OP_LOCK_SET, 16'hF800, 16'h1234, 4'h1);
        chk("lock_sw", 16'h000E, {12'h0, lock_bits});
        do_store(frs_pkg::OP_PAGE_WRITE, 16'hF800, 16'h0100, 4'h0);
        chk("refused_app", 16'h1, {15'h0, ref_});
        chk("go_app_lock", 16'h0, {15'h0, go});
        do_store(frs_pkg::OP_PAGE_WRITE, 16'hF800, 16'hF900, 4'h0);
        chk("go_boot_open", 16'h1, {15'h0, go});
        wait_done(1'b1);
        @(posedge clk);
        lock_prog <= 1'b1;
        prog_mask <= 4'h4;
        @(posedge clk);
        lock_prog <= 1'b0;
        #1;
        chk("lock_prog", 16'h000A, {12'h0, lock_bits});
        do_store(frs_pkg::OP_PAGE_WRITE, 16'hF800, 16'hF900, 4'h0);
        chk("refused_boot", 16'h1, {15'h0, ref_});
        reg_read(frs_pkg::REG_CTRL, 8'h08, "ctrl_refused");
        reg_write(frs_pkg::REG_CTRL, 8'h08);
        reg_read(frs_pkg::REG_CTRL, 8'h00, "ctrl_refused_clr");
        do_store(2'h3, 16'hF800, 16'hF900, 4'h0);
        chk("ignored_op3", 16'h1, {15'h0, ign});
        @(posedge clk);
        chip_erase <= 1'b1;
        @(posedge clk);
        chip_erase <= 1'b0;
        #1;
        chk("lock_erase", 16'h000F, {12'h0, lock_bits});
    endtask : t_locks

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        {nrst, store, lock_prog, chip_erase, reg_wr, reg_rd} = '0;
        {store_op, fuses, reg_addr, exec_addr, ptr, store_data, prog_mask, wdata} = '0;
        lock_stored  = 4'hF;
        delay        = 8'd4;
        fails        = 0;
        total_checks = 0;
        t_fuse_split();
        t_conc_write();
        t_halt_ops();
        t_locks();
        tally_and_finish();
    end

    initial begin
        #100000;
        fails++;
        tally_and_finish();
    end
endmodule : frs_section_ctrl_tb
